// [rtl/apr_defs.vh]
`ifndef APR_DEFS_VH
`define APR_DEFS_VH

// ------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------
`define APR_IDX_MODE_CFG     10'h068
`define APR_IDX_TARGET       10'h069
`define APR_IDX_LOAD_HYS     10'h06B
`define APR_IDX_UNLOAD_HYS   10'h06E
`define APR_IDX_LOW_LIMIT    10'h06F
`define APR_IDX_STRENGTH     10'h070
`define APR_IDX_METHOD       10'h071
`define APR_IDX_INIT_GATE    10'h072
`define APR_IDX_DROPOUT      10'h073
`define APR_IDX_GUARD        10'h079
`define APR_IDX_FDT_EN       10'h07A
`define APR_IDX_AFTER_RX     10'h07B
`define APR_IDX_STATUS       10'h0F0
`define APR_IDX_LAST_MEAS    10'h0F1
`define APR_IDX_LUT          10'h100
`define APR_LUT_DEPTH        10'h021
`define APR_LUT_LAST         6'h20

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define APR_RST_MODE_CFG     3'h7
`define APR_RST_TARGET       16'h00C8
`define APR_RST_LOAD_HYS     8'h0A
`define APR_RST_UNLOAD_HYS   8'h0A
`define APR_RST_LOW_LIMIT    8'h00
`define APR_RST_STRENGTH     8'h00
`define APR_RST_METHOD       8'h00
`define APR_RST_INIT_GATE    8'h00
`define APR_RST_DROPOUT      16'h0E10
`define APR_RST_GUARD        8'h0A
`define APR_RST_FDT_EN       8'h01
`define APR_RST_AFTER_RX     8'h01

// ------------------------------------------------------------
// selector codes and levels
// ------------------------------------------------------------
`define APR_METHOD_OFF       8'h00
`define APR_METHOD_ONRES     8'h01
`define APR_METHOD_PWM       8'h02
`define APR_SEL_ON           8'h01
`define APR_SUPPLY_MAX       8'hFF
`define APR_SUPPLY_SAFE      8'h80
`define APR_PWM_MAX          8'hFF
`define APR_RES_BASE_MOHM    16'h2710
`define APR_RES_MIN_MOHM     16'h01F4
`define APR_RES_STEP_LIMIT   8'h14

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define APR_CLK_NS           8
`define APR_GUARD_UNIT_NS    1000
`define APR_US_CYC           (`APR_GUARD_UNIT_NS / `APR_CLK_NS)

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define APR_RESP_OKAY        2'h0
`define APR_RESP_SLVERR      2'h2

`endif

// [rtl/apr_lut_mem.v]
`timescale 1ns/100ps
module apr_lut_mem (
  sys_clk,
  wrEn,
  wrAddr,
  wrData,
  rdAddr,
  rdData
);
  input  wire       sys_clk;
  input  wire       wrEn;
  input  wire [5:0] wrAddr;
  input  wire [7:0] wrData;
  input  wire [5:0] rdAddr;
  output reg  [7:0] rdData;

  // no reset on the array: software loads it before enabling regulation
  reg [7:0] mem [0:32];

  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// [rtl/apr_regulation.v]
// Contract
// - hold 16-bit target current, limit plus/minus margins
// - lower target by voltage-indexed reduction table entry
// - step supply down above target plus loading margin
// - raise supply below target minus unloading margin
// - keep 8-bit supply floor for on-resistance method
// - strength n maps to 10/(n+1) or 0.5 ohm
// - method select 0 off, 1 on-resistance, 2 pwm
// - load both gate settings at carrier switch on
// - check dropout at switch on, go safe or stop
// - dropout limit in mV, default 3600
// - guard time 8-bit in microseconds
// - one pass before transmit, one after receive
// - always wait guard time before transmit starts
// - wait guard time after receive before pass
// - frame delay selector 0 off, 1 on
// - after-receive selector 0 off, 1 on
// - one enable bit per radio mode
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "apr_defs.vh"
module apr_regulation (
  sys_clk,
  resetn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  carrierSwitchOn,
  rfMode,
  txReq,
  rxDone,
  inFrameDelay,
  boostBypass,
  measCurrent,
  regulatorDropout,
  supplyVoltIdx,
  supplyLevel,
  supplyStop,
  driverGateSetting1,
  driverGateSetting2,
  pwmDuty,
  driverOnResMohm,
  txStart,
  regBusy,
  dropoutTrip
);
  input  wire        sys_clk;
  input  wire        resetn;
  input  wire [11:0] s_axi_awaddr;
  input  wire        s_axi_awvalid;
  output reg         s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output reg         s_axi_wready;
  output reg  [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [11:0] s_axi_araddr;
  input  wire        s_axi_arvalid;
  output reg         s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;
  input  wire        carrierSwitchOn;
  input  wire [1:0]  rfMode;
  input  wire        txReq;
  input  wire        rxDone;
  input  wire        inFrameDelay;
  input  wire        boostBypass;
  input  wire [15:0] measCurrent;
  input  wire [15:0] regulatorDropout;
  input  wire [5:0]  supplyVoltIdx;
  output reg  [7:0]  supplyLevel;
  output reg         supplyStop;
  output wire [7:0]  driverGateSetting1;
  output wire [7:0]  driverGateSetting2;
  output reg  [7:0]  pwmDuty;
  output reg  [15:0] driverOnResMohm;
  output reg         txStart;
  output reg         regBusy;
  output reg         dropoutTrip;

  localparam [2:0] ST_IDLE       = 3'h0;
  localparam [2:0] ST_PRE_REG    = 3'h1;
  localparam [2:0] ST_PRE_GUARD  = 3'h2;
  localparam [2:0] ST_TX         = 3'h3;
  localparam [2:0] ST_POST_GUARD = 3'h4;
  localparam [2:0] ST_POST_REG   = 3'h5;
  localparam integer US_CYC      = `APR_US_CYC;
  localparam [6:0] US_LAST       = US_CYC[6:0] - 7'h01;

  // ----------------------------------------------------------
  // functions
  // ----------------------------------------------------------
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {(s[1] ? d[15:8] : old[15:8]), (s[0] ? d[7:0] : old[7:0])};
    end
  endfunction

  function lutHit;
    input [9:0] idx;
    begin
      lutHit = (idx >= `APR_IDX_LUT) && (idx < (`APR_IDX_LUT + `APR_LUT_DEPTH));
    end
  endfunction

  function regHit;
    input [9:0] idx;
    begin
      case (idx)
        `APR_IDX_MODE_CFG, `APR_IDX_TARGET, `APR_IDX_LOAD_HYS,
        `APR_IDX_UNLOAD_HYS, `APR_IDX_LOW_LIMIT, `APR_IDX_STRENGTH,
        `APR_IDX_METHOD, `APR_IDX_INIT_GATE, `APR_IDX_DROPOUT,
        `APR_IDX_GUARD, `APR_IDX_FDT_EN, `APR_IDX_AFTER_RX,
        `APR_IDX_STATUS, `APR_IDX_LAST_MEAS: regHit = 1'b1;
        default: regHit = lutHit(idx);
      endcase
    end
  endfunction

  function [15:0] resMohm;
    input [7:0] n;
    reg   [15:0] den;
    begin
      den = {8'h00, n} + 16'h0001;
      if (n < `APR_RES_STEP_LIMIT) begin
        resMohm = `APR_RES_BASE_MOHM / den;
      end else begin
        resMohm = `APR_RES_MIN_MOHM;
      end
    end
  endfunction

  // ----------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------
  reg [2:0]  modeCfg_reg;
  reg [15:0] target_reg;
  reg [7:0]  loadHys_reg;
  reg [7:0]  unloadHys_reg;
  reg [7:0]  lowLimit_reg;
  reg [7:0]  strength_reg;
  reg [7:0]  method_reg;
  reg [7:0]  initGate_reg;
  reg [15:0] dropLimit_reg;
  reg [7:0]  guard_reg;
  reg [7:0]  fdtSel_reg;
  reg [7:0]  afterRx_reg;
  reg [11:0] wAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0]  wStrb_reg;
  reg        awHeld_reg;
  reg        wHeld_reg;
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [7:0]  gate_reg;
  reg [15:0] lastMeas_reg;
  reg [7:0]  guardCnt_reg;
  reg [6:0]  usCnt_reg;
  reg        fieldDly_reg;
  reg [31:0] rdMux;

  wire [9:0] wIdx     = wAddr_reg[11:2];
  wire [9:0] rIdx     = s_axi_araddr[11:2];
  wire [9:0] wLutOff  = wIdx - `APR_IDX_LUT;
  wire       doWrite  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire [7:0] reduction;
  wire [5:0] lutRdIdx = (supplyVoltIdx > `APR_LUT_LAST) ? `APR_LUT_LAST : supplyVoltIdx;

  assign driverGateSetting1 = gate_reg;
  assign driverGateSetting2 = gate_reg;

  apr_lut_mem u_lut (
    .sys_clk (sys_clk),
    .wrEn    (doWrite && lutHit(wIdx) && wStrb_reg[0]),
    .wrAddr  (wLutOff[5:0]),
    .wrData  (wData_reg[7:0]),
    .rdAddr  (lutRdIdx),
    .rdData  (reduction)
  );

  // ----------------------------------------------------------
  // bus slave, write path
  // ----------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `APR_RESP_OKAY;
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      wAddr_reg     <= 12'h000;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      modeCfg_reg   <= `APR_RST_MODE_CFG;
      target_reg    <= `APR_RST_TARGET;
      loadHys_reg   <= `APR_RST_LOAD_HYS;
      unloadHys_reg <= `APR_RST_UNLOAD_HYS;
      lowLimit_reg  <= `APR_RST_LOW_LIMIT;
      strength_reg  <= `APR_RST_STRENGTH;
      method_reg    <= `APR_RST_METHOD;
      initGate_reg  <= `APR_RST_INIT_GATE;
      dropLimit_reg <= `APR_RST_DROPOUT;
      guard_reg     <= `APR_RST_GUARD;
      fdtSel_reg    <= `APR_RST_FDT_EN;
      afterRx_reg   <= `APR_RST_AFTER_RX;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wAddr_reg     <= s_axi_awaddr;
        awHeld_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
        wHeld_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= regHit(wIdx) ? `APR_RESP_OKAY : `APR_RESP_SLVERR;
        case (wIdx)
          `APR_IDX_MODE_CFG: if (wStrb_reg[0]) modeCfg_reg <= wData_reg[2:0];
          `APR_IDX_TARGET: target_reg <= merge16(target_reg, wData_reg, wStrb_reg);
          `APR_IDX_LOAD_HYS: if (wStrb_reg[0]) loadHys_reg <= wData_reg[7:0];
          `APR_IDX_UNLOAD_HYS: if (wStrb_reg[0]) unloadHys_reg <= wData_reg[7:0];
          `APR_IDX_LOW_LIMIT: if (wStrb_reg[0]) lowLimit_reg <= wData_reg[7:0];
          `APR_IDX_STRENGTH: if (wStrb_reg[0]) strength_reg <= wData_reg[7:0];
          `APR_IDX_METHOD: if (wStrb_reg[0]) method_reg <= wData_reg[7:0];
          `APR_IDX_INIT_GATE: if (wStrb_reg[0]) initGate_reg <= wData_reg[7:0];
          `APR_IDX_DROPOUT: dropLimit_reg <= merge16(dropLimit_reg, wData_reg, wStrb_reg);
          `APR_IDX_GUARD: if (wStrb_reg[0]) guard_reg <= wData_reg[7:0];
          `APR_IDX_FDT_EN: if (wStrb_reg[0]) fdtSel_reg <= wData_reg[7:0];
          `APR_IDX_AFTER_RX: if (wStrb_reg[0]) afterRx_reg <= wData_reg[7:0];
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // bus slave, read path
  // ----------------------------------------------------------
  // table entries are write-only: the single read port serves the regulator
  always @* begin
    rdMux = 32'h00000000;
    case (rIdx)
      `APR_IDX_MODE_CFG:   rdMux[2:0]  = modeCfg_reg;
      `APR_IDX_TARGET:     rdMux[15:0] = target_reg;
      `APR_IDX_LOAD_HYS:   rdMux[7:0]  = loadHys_reg;
      `APR_IDX_UNLOAD_HYS: rdMux[7:0]  = unloadHys_reg;
      `APR_IDX_LOW_LIMIT:  rdMux[7:0]  = lowLimit_reg;
      `APR_IDX_STRENGTH:   rdMux[7:0]  = strength_reg;
      `APR_IDX_METHOD:     rdMux[7:0]  = method_reg;
      `APR_IDX_INIT_GATE:  rdMux[7:0]  = initGate_reg;
      `APR_IDX_DROPOUT:    rdMux[15:0] = dropLimit_reg;
      `APR_IDX_GUARD:      rdMux[7:0]  = guard_reg;
      `APR_IDX_FDT_EN:     rdMux[7:0]  = fdtSel_reg;
      `APR_IDX_AFTER_RX:   rdMux[7:0]  = afterRx_reg;
      `APR_IDX_STATUS:     rdMux[21:0] = {state_reg, regBusy, dropoutTrip, supplyStop,
                                          gate_reg, supplyLevel};
      `APR_IDX_LAST_MEAS:  rdMux[15:0] = lastMeas_reg;
      default:             rdMux = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `APR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= regHit(rIdx) ? `APR_RESP_OKAY : `APR_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // regulation decision
  // ----------------------------------------------------------
  wire [16:0] tgtEff  = (target_reg > {8'h00, reduction}) ?
                        {1'b0, target_reg - {8'h00, reduction}} : 17'h00000;
  wire [16:0] upper   = tgtEff + {9'h000, loadHys_reg};
  wire        lowOk   = tgtEff >= {9'h000, unloadHys_reg};
  wire [16:0] lower   = tgtEff - {9'h000, unloadHys_reg};
  wire [16:0] meas17  = {1'b0, measCurrent};
  wire        needDn  = meas17 > upper;
  wire        needUp  = lowOk && (meas17 < lower);
  wire        mOnRes  = method_reg == `APR_METHOD_ONRES;
  wire        mPwm    = method_reg == `APR_METHOD_PWM;
  // reserved method codes behave as disabled: no floor, no gate trimming
  wire [7:0]  floor   = (mOnRes || mPwm) ? lowLimit_reg : 8'h00;
  wire        modeOn  = (rfMode == 2'h3) ? 1'b0 : modeCfg_reg[rfMode];
  wire        fdtOk   = !inFrameDelay || (fdtSel_reg == `APR_SEL_ON);
  wire        passOk  = modeOn && fdtOk && carrierSwitchOn && !supplyStop;
  wire        rxPass  = afterRx_reg == `APR_SEL_ON;
  wire        fieldUp = carrierSwitchOn && !fieldDly_reg;
  wire        usTick  = usCnt_reg == US_LAST;

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (txReq) begin
          state_next = ST_PRE_REG;
        end else if (rxDone && rxPass) begin
          state_next = ST_POST_GUARD;
        end
      end
      ST_PRE_REG:    state_next = ST_PRE_GUARD;
      ST_PRE_GUARD:  if (guardCnt_reg == 8'h00) state_next = ST_TX;
      ST_TX:         state_next = ST_IDLE;
      ST_POST_GUARD: if (guardCnt_reg == 8'h00) state_next = ST_POST_REG;
      ST_POST_REG:   state_next = ST_IDLE;
      default:       state_next = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg       <= ST_IDLE;
      supplyLevel     <= `APR_SUPPLY_SAFE;
      supplyStop      <= 1'b0;
      dropoutTrip     <= 1'b0;
      gate_reg        <= `APR_RST_INIT_GATE;
      pwmDuty         <= `APR_PWM_MAX;
      driverOnResMohm <= `APR_RES_BASE_MOHM;
      txStart         <= 1'b0;
      regBusy         <= 1'b0;
      lastMeas_reg    <= 16'h0000;
      guardCnt_reg    <= 8'h00;
      usCnt_reg       <= 7'h00;
      fieldDly_reg    <= 1'b0;
    end else begin
      state_reg       <= state_next;
      regBusy         <= state_next != ST_IDLE;
      txStart         <= (state_reg == ST_PRE_GUARD) && (state_next == ST_TX);
      fieldDly_reg    <= carrierSwitchOn;
      driverOnResMohm <= resMohm(strength_reg);
      // guard counter restarts the microsecond divider so no wait runs short
      if (state_next != state_reg) begin
        guardCnt_reg <= guard_reg;
        usCnt_reg    <= 7'h00;
      end else if (usTick) begin
        usCnt_reg <= 7'h00;
        if (guardCnt_reg != 8'h00) begin
          guardCnt_reg <= guardCnt_reg - 8'h01;
        end
      end else begin
        usCnt_reg <= usCnt_reg + 7'h01;
      end
      if (fieldUp) begin
        gate_reg <= initGate_reg;
        pwmDuty  <= `APR_PWM_MAX;
        if (regulatorDropout > dropLimit_reg) begin
          dropoutTrip <= 1'b1;
          supplyStop  <= boostBypass;
          supplyLevel <= boostBypass ? supplyLevel : `APR_SUPPLY_SAFE;
        end else begin
          dropoutTrip <= 1'b0;
          supplyStop  <= 1'b0;
          supplyLevel <= `APR_SUPPLY_MAX;
        end
      end else if (((state_reg == ST_PRE_REG) || (state_reg == ST_POST_REG)) && passOk) begin
        lastMeas_reg <= measCurrent;
        if (needDn) begin
          if (supplyLevel > floor) begin
            supplyLevel <= supplyLevel - 8'h01;
          end else if (mOnRes && (gate_reg != 8'h00)) begin
            gate_reg <= gate_reg - 8'h01;
          end else if (mPwm && (pwmDuty != 8'h00)) begin
            pwmDuty <= pwmDuty - 8'h01;
          end
        end else if (needUp) begin
          if (mOnRes && (gate_reg < initGate_reg)) begin
            gate_reg <= gate_reg + 8'h01;
          end else if (mPwm && (pwmDuty != `APR_PWM_MAX)) begin
            pwmDuty <= pwmDuty + 8'h01;
          end else if (supplyLevel != `APR_SUPPLY_MAX) begin
            supplyLevel <= supplyLevel + 8'h01;
          end
        end
      end
    end
  end
endmodule

// [sim/apr_regulation_properties.sv]
`timescale 1ns/100ps
module apr_regulation_checker (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       carrierSwitchOn,
  input wire logic       boostBypass,
  input wire logic [7:0] supplyLevel,
  input wire logic       supplyStop,
  input wire logic [7:0] driverGateSetting1,
  input wire logic [7:0] driverGateSetting2,
  input wire logic       txStart,
  input wire logic       regBusy,
  input wire logic       dropoutTrip
);
  // ----------------------------------------
  // field settle tracking
  // ----------------------------------------
  // field rise rewrites the supply at once, so step checks wait it out
  logic [2:0] riseAge_reg;
  logic       carrier_switch_on_reg;
  wire        settled = (riseAge_reg == 3'h7) && carrierSwitchOn;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      riseAge_reg <= 3'h7;
      carrier_switch_on_reg <= 1'b0;
    end else begin
      carrier_switch_on_reg <= carrierSwitchOn;
      if (carrierSwitchOn && !carrier_switch_on_reg) riseAge_reg <= 3'h0;
      else if (riseAge_reg != 3'h7) riseAge_reg <= riseAge_reg + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_TX_PULSE: assert property (txStart |=> !txStart)
    else $error("tx start longer than one cycle");
  AST_GATE_PAIR: assert property (settled && $changed(driverGateSetting1) |->
    driverGateSetting2 == driverGateSetting1 && $past(regBusy))
    else $error("gate moved outside a pass or settings differ");
  AST_FIELD_ON: assert property ($rose(carrierSwitchOn) |-> ##[1:2] (dropoutTrip ?
    (boostBypass ? supplyStop : supplyLevel == 8'h80) : (supplyLevel == 8'hFF && !supplyStop)))
    else $error("field on supply setup wrong");
  AST_ONE_STEP: assert property (settled && $changed(supplyLevel) |->
    supplyLevel == $past(supplyLevel) + 8'h01 || supplyLevel == $past(supplyLevel) - 8'h01)
    else $error("supply moved more than one step");
  AST_STEP_BUSY: assert property (settled && $changed(supplyLevel) |-> $past(regBusy))
    else $error("supply moved outside a pass");
  AST_STOP_FREEZE: assert property (settled && $past(supplyStop) |-> $stable(supplyLevel))
    else $error("stopped supply changed");
  AST_TX_AFTER_BUSY: assert property (txStart |-> $past(regBusy))
    else $error("tx start without a pass");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  cover property (txStart);
  cover property (dropoutTrip && supplyStop);
  cover property (settled && $changed(supplyLevel));
endmodule

bind apr_regulation apr_regulation_checker apr_regulation_checker_inst (.*);

// [sim/apr_supply_model.sv]
`timescale 1ns/100ps
module apr_supply_model (
  input  wire logic        carrierSwitchOn,
  input  wire logic        supplyStop,
  input  wire logic [15:0] loadMa,
  output logic      [15:0] measCurrent
);
  // no field or a stopped supply means the sensor sees no current
  assign measCurrent = (carrierSwitchOn && !supplyStop) ? loadMa : 16'h0000;
endmodule

// [sim/tb.sv]
`timescale 1ns/100ps
`include "apr_defs.vh"
module tb;
  logic        sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, carrierSwitchOn, txReq, rxDone, inFrameDelay, boostBypass;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        supplyStop, txStart, regBusy, dropoutTrip;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rfMode, s_axi_bresp, s_axi_rresp;
  logic [15:0] loadMa, measCurrent, regulatorDropout, driverOnResMohm;
  logic [5:0]  supplyVoltIdx;
  logic [7:0]  supplyLevel, driverGateSetting1, driverGateSetting2, pwmDuty;
  int          err_count = 0, checks_done = 0;
  int          sup, gt, pw, ig, meth, flr, lut, mode, fdt, arx;

  apr_regulation apr_regulation_inst (.*);
  apr_supply_model apr_supply_model_inst (.*);

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge sys_clk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask

  task automatic rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge sys_clk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  // one regulation pass against the reference model, target 200 and margins 10
  task automatic pass(input int ld, input logic rx, input int g);
    int n, t;
    @(posedge sys_clk);
    loadMa <= ld[15:0];
    repeat (2) @(posedge sys_clk);
    if (rx) rxDone <= 1'b1;
    else txReq <= 1'b1;
    @(posedge sys_clk);
    rxDone <= 1'b0;
    txReq <= 1'b0;
    n = 0;
    if (rx) repeat (g * 125 + 10) @(posedge sys_clk);
    else begin
      while (txStart !== 1'b1 && n < 2000) begin
        @(posedge sys_clk);
        n++;
      end
      chk("txdelay", 1, n >= g * 125 + 2 && n <= g * 125 + 4);
    end
    repeat (3) @(posedge sys_clk);
    if (mode[rfMode] && rfMode != 2'h3 && !(inFrameDelay && fdt != 1) && (!rx || arx == 1)) begin
      t = (200 > lut) ? 200 - lut : 0;
      if (ld > t + 10) begin
        if (sup > flr) sup--;
        else if (meth == 1) gt--;
        else if (meth == 2) pw--;
      end else if (t >= 10 && ld < t - 10 && sup < 255) sup++;
    end
    chk("supply", sup, supplyLevel);
    chk("gate", gt, driverGateSetting1);
    chk("pwm", pw, pwmDuty);
  endtask

  task automatic fon(input logic [15:0] d, input logic b);
    @(posedge sys_clk);
    carrierSwitchOn <= 1'b0;
    regulatorDropout <= d;
    boostBypass <= b;
    repeat (3) @(posedge sys_clk);
    carrierSwitchOn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("trip", d > 16'h0E10, dropoutTrip);
    chk("stop", b && d > 16'h0E10, supplyStop);
    if (!(b && d > 16'h0E10)) chk("supply", d > 16'h0E10 ? 8'h80 : 8'hFF, supplyLevel);
    chk("gate", ig, driverGateSetting2);
    sup = 255;
    gt = ig;
    pw = 255;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end

  initial begin
    int sv[6];
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {carrierSwitchOn, txReq, rxDone, inFrameDelay, boostBypass, rfMode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, supplyVoltIdx} = '0;
    s_axi_wstrb = 4'hF;
    loadMa = 16'h00C8;
    regulatorDropout = 16'h03E8;
    void'($urandom(32'hF280));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`APR_IDX_DROPOUT, 32'h00000E10);
    rd(`APR_IDX_TARGET, 32'h000000C8);
    rd(`APR_IDX_MODE_CFG, 32'h00000007);
    rd(`APR_IDX_LOAD_HYS, 32'h0000000A);
    rd(`APR_IDX_UNLOAD_HYS, 32'h0000000A);
    rd(`APR_IDX_GUARD, 32'h0000000A);
    rd(10'h3FF, 32'h0, `APR_RESP_SLVERR);
    wr(10'h3FF, 32'h5, `APR_RESP_SLVERR);
    sv = '{0, 1, 19, 20, 255, 0};
    sv[5] = $urandom % 256;
    foreach (sv[i]) begin
      wr(`APR_IDX_STRENGTH, sv[i]);
      repeat (2) @(posedge sys_clk);
      chk("onres", sv[i] < 20 ? 16'h2710 / (sv[i] + 1) : 16'h01F4, driverOnResMohm);
    end
    ig = 1 + $urandom % 254;
    wr(`APR_IDX_INIT_GATE, ig);
    rd(`APR_IDX_INIT_GATE, ig);
    wr(`APR_IDX_GUARD, 32'h0);
    wr(`APR_IDX_LUT, 32'h0);
    wr(`APR_IDX_LUT + 10'h005, 32'h1E);
    {meth, flr, lut, mode, fdt, arx} = {32'd0, 32'd0, 32'd0, 32'd7, 32'd1, 32'd1};
    fon(16'h03E8, 1'b0);
    pass(211, 0, 0);
    pass(210, 0, 0);
    pass(189, 0, 0);
    pass(190, 0, 0);
    supplyVoltIdx <= 6'h05;
    lut = 30;
    pass(181, 0, 0);
    supplyVoltIdx <= 6'h00;
    lut = 0;
    rfMode <= 2'h3;
    pass(211, 0, 0);
    rfMode <= 2'h0;
    wr(`APR_IDX_MODE_CFG, 32'h6);
    mode = 6;
    pass(211, 0, 0);
    rfMode <= 2'h1;
    pass(211, 0, 0);
    rfMode <= 2'h0;
    wr(`APR_IDX_MODE_CFG, 32'h7);
    mode = 7;
    inFrameDelay <= 1'b1;
    pass(211, 0, 0);
    wr(`APR_IDX_FDT_EN, 32'h0);
    fdt = 0;
    pass(211, 0, 0);
    inFrameDelay <= 1'b0;
    repeat (4) pass(150 + $urandom % 100, 0, 0);
    wr(`APR_IDX_GUARD, 32'h1);
    pass(211, 0, 1);
    rd(`APR_IDX_LAST_MEAS, 32'd211);
    pass(150, 1, 1);
    wr(`APR_IDX_AFTER_RX, 32'h0);
    arx = 0;
    pass(211, 1, 1);
    wr(`APR_IDX_GUARD, 32'h0);
    wr(`APR_IDX_LOW_LIMIT, 32'hFF);
    for (int m = 1; m < 4; m++) begin
      wr(`APR_IDX_METHOD, m);
      meth = m;
      flr = (m < 3) ? 255 : 0;
      pass(211, 0, 0);
    end
    fon(16'h0E10, 1'b0);
    fon(16'h0E11, 1'b0);
    fon(16'h0E11, 1'b1);
    repeat (12) @(posedge sys_clk);
    chk("stopheld", 1, supplyStop);
    finish_test();
  end
endmodule
